// [ccbs_top.sv]
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ccbs_top #(
   parameter int TICK_CYCLES = ccbs_pkg::TICK_CYCLES,
   parameter int BUS_LOSS_S  = ccbs_pkg::BUS_LOSS_S
) (
   input  wire logic                        clock,
   input  wire logic                        reset,
   input  wire logic [ccbs_pkg::ADDR_W-1:0] address,
   input  wire logic [ccbs_pkg::DATA_W-1:0] write_data,
   input  wire logic                        write_strobe,
   input  wire logic                        read_strobe,
   output logic      [ccbs_pkg::DATA_W-1:0] read_data,
   output logic                             irq,
   input  wire logic                        rx_valid,
   input  wire logic [19:0]                 rx_time,
   input  wire logic [15:0]                 rx_date,
   input  wire logic                        rx_master_seen,
   output logic                             tx_valid,
   output logic                             tx_adjust,
   output logic      [19:0]                 tx_time,
   output logic      [15:0]                 tx_date
);
   import ccbs_pkg::*;

   // Configuration
   logic       fmt_12h;      // Presentation format
   logic [1:0] mode;         // Bus time role
   logic       remote_adj;   // Follower may set system time
   logic [4:0] sum_day;      // Earliest summer changeover
   logic [3:0] sum_mon;
   logic [4:0] win_day;      // Earliest winter changeover
   logic [3:0] win_mon;
   // Clock state
   logic [5:0] sec;
   logic [5:0] min;
   logic [4:0] hour;
   logic [2:0] wday;         // 0 is Monday
   logic [4:0] day;
   logic [3:0] mon;
   logic [6:0] year;         // Years past 2000
   logic       dst_on;       // Summer time in force
   logic       sum_pend;     // Summer start date passed
   logic       win_pend;     // Winter start date passed
   logic       invalid;      // Time lost and not yet set
   // Faults and interrupts
   logic       multi;        // Latched until acknowledged
   logic [ST_W-1:0] status;
   logic [ST_W-1:0] mask;
   logic [ST_W-1:0] fault_q; // Previous fault levels
   // Timebase and transmit requests
   logic [31:0] tick_cnt;
   logic        tick;
   logic [15:0] loss_cnt;    // Seconds without bus time
   logic        blink;
   logic        tx_pend;
   logic        tx_pend_adj;

   // Days in a month; 2000 is leap, 2100 is not
   function automatic logic [4:0] month_len(input logic [3:0] m,
                                            input logic [6:0] y);
      logic leap;
      leap = (y[1:0] == 2'h0) && (y != 7'h64);
      case (m)
         4'h2:    month_len = leap ? 5'h1D : 5'h1C;
         4'h4,
         4'h6,
         4'h9,
         4'hB:    month_len = 5'h1E;
         default: month_len = 5'h1F;
      endcase
   endfunction

   // Control, time and date strobes decoded once
   logic wr_ctrl;
   logic wr_time;
   logic wr_date;
   logic local_ok;
   logic follow;
   logic master;
   assign wr_ctrl = write_strobe && (address == OFS_CTRL);
   assign wr_time = write_strobe && (address == OFS_TIME);
   assign wr_date = write_strobe && (address == OFS_DATE);
   assign follow  = (mode == MODE_FOLLOW);
   assign master  = (mode == MODE_MASTER);
   // Standalone and master always accept; follower only with remote
   assign local_ok = !follow || remote_adj;

   // Bus time is taken only as follower, so standalone ignores it
   logic bus_load;
   assign bus_load = rx_valid && follow;

   // Next-second arithmetic
   logic       sec_end;
   logic       min_end;
   logic       day_end;
   logic       date_end;
   logic       same_dates;
   logic       to_summer;
   logic       to_winter;
   logic [4:0] next_day;
   logic [3:0] next_mon;
   logic [6:0] next_year;
   always_comb begin
      sec_end  = (sec == 6'h3B);
      min_end  = sec_end && (min == 6'h3B);
      day_end  = min_end && (hour == 5'h17);
      date_end = (day == month_len(mon, year));
      next_day  = date_end ? 5'h01 : day + 5'h01;
      next_mon  = mon;
      next_year = year;
      if (date_end) begin
         next_mon = (mon == 4'hC) ? 4'h1 : mon + 4'h1;
         if (mon == 4'hC) begin
            next_year = year + 7'h01;
         end
      end
      same_dates = (sum_day == win_day) && (sum_mon == win_mon);
      // Shift only after the start date, never on it
      to_summer = min_end && (hour == 5'h01) && (wday == SUNDAY)
                  && sum_pend && !dst_on && !same_dates
                  && !((day == sum_day) && (mon == sum_mon));
      to_winter = min_end && (hour == 5'h02) && (wday == SUNDAY)
                  && win_pend && dst_on && !same_dates
                  && !((day == win_day) && (mon == win_mon));
   end

   // One-second tick from the system clock
   always_ff @(posedge clock) begin
      if (reset || tick) begin
         tick_cnt <= 32'h0;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
      end
   end
   assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

   // Configuration registers
   always_ff @(posedge clock) begin
      if (reset) begin
         fmt_12h    <= 1'b0;
         mode       <= MODE_ALONE;
         remote_adj <= 1'b1;
         sum_day    <= RST_SUM_DAY;
         sum_mon    <= RST_SUM_MON;
         win_day    <= RST_WIN_DAY;
         win_mon    <= RST_WIN_MON;
      end else if (wr_ctrl) begin
         fmt_12h    <= write_data[0];
         mode       <= write_data[2:1];
         remote_adj <= write_data[3];
      end else if (write_strobe && (address == OFS_SEASON)) begin
         sum_day <= write_data[4:0];
         sum_mon <= write_data[11:8];
         win_day <= write_data[20:16];
         win_mon <= write_data[27:24];
      end
   end

   // Time of day, weekday and date
   always_ff @(posedge clock) begin
      if (reset) begin
         sec  <= 6'h00;
         min  <= 6'h00;
         hour <= 5'h00;
         wday <= RST_WDAY;
         day  <= 5'h01;
         mon  <= 4'h1;
         year <= 7'h00;
      end else if (bus_load) begin
         // Follower aligns to system time, whatever the remote setting
         sec  <= rx_time[5:0];
         min  <= rx_time[11:6];
         hour <= rx_time[16:12];
         wday <= rx_time[19:17];
         day  <= rx_date[4:0];
         mon  <= rx_date[8:5];
         year <= rx_date[15:9];
      end else if (wr_time && local_ok) begin
         sec  <= write_data[5:0];
         min  <= write_data[13:8];
         hour <= write_data[20:16];
         wday <= write_data[26:24];
      end else if (wr_date && local_ok) begin
         day  <= write_data[4:0];
         mon  <= write_data[11:8];
         year <= write_data[22:16];
      end else if (tick) begin
         if (to_summer) begin
            // Skip the hour from 02:00 straight to 03:00
            sec  <= 6'h00;
            min  <= 6'h00;
            hour <= 5'h03;
         end else if (to_winter) begin
            // Repeat the hour once; win_pend stops a loop
            sec  <= 6'h00;
            min  <= 6'h00;
            hour <= 5'h02;
         end else begin
            sec <= sec_end ? 6'h00 : sec + 6'h01;
            if (sec_end) begin
               min <= min_end ? 6'h00 : min + 6'h01;
            end
            if (min_end) begin
               hour <= day_end ? 5'h00 : hour + 5'h01;
            end
            if (day_end) begin
               wday <= (wday == SUNDAY) ? 3'h0 : wday + 3'h1;
               day  <= next_day;
               mon  <= next_mon;
               year <= next_year;
            end
         end
      end
   end

   // Season state: arm on reaching a start date, fire on Sunday
   always_ff @(posedge clock) begin
      if (reset) begin
         dst_on   <= 1'b0;
         sum_pend <= 1'b0;
         win_pend <= 1'b0;
      end else if (tick) begin
         if (to_summer) begin
            dst_on   <= 1'b1;
            sum_pend <= 1'b0;
         end else if (to_winter) begin
            dst_on   <= 1'b0;
            win_pend <= 1'b0;
         end else if (day_end && !same_dates) begin
            if ((next_day == sum_day) && (next_mon == sum_mon)) begin
               sum_pend <= 1'b1;
            end
            if ((next_day == win_day) && (next_mon == win_mon)) begin
               win_pend <= 1'b1;
            end
         end
      end
   end

   // Validity: lost at power-up, restored by any accepted setting
   always_ff @(posedge clock) begin
      if (reset) begin
         invalid <= 1'b1;
      end else if (bus_load || ((wr_time || wr_date) && local_ok)) begin
         invalid <= 1'b0;
      end
   end

   // Bus-loss watch counts seconds since the last bus time
   always_ff @(posedge clock) begin
      if (reset || bus_load) begin
         loss_cnt <= 16'h0;
      end else if (tick && (loss_cnt != 16'(BUS_LOSS_S))) begin
         loss_cnt <= loss_cnt + 16'h1;
      end
   end

   // Fault levels; 5001 and 5003 clear themselves
   logic            bus_lost;
   logic [ST_W-1:0] fault;
   assign bus_lost = (loss_cnt == 16'(BUS_LOSS_S));
   always_comb begin
      fault             = '0;
      fault[ST_SYSFAIL] = follow && bus_lost;
      fault[ST_MULTI]   = multi;
      fault[ST_INVALID] = invalid && (bus_lost || !follow);
      fault[ST_SHIFT]   = 1'b0;
   end

   // Second master seen: latch until software writes its status bit
   always_ff @(posedge clock) begin
      if (reset) begin
         multi <= 1'b0;
      end else if (master && rx_master_seen) begin
         multi <= 1'b1;
      end else if (write_strobe && (address == OFS_STATUS)
                   && write_data[ST_MULTI]) begin
         multi <= 1'b0;
      end
   end

   // Sticky status: rising faults and seasonal shifts; set wins
   logic [ST_W-1:0] events;
   always_comb begin
      events           = fault & ~fault_q;
      events[ST_SHIFT] = tick && (to_summer || to_winter);
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         fault_q <= '0;
         status  <= '0;
      end else begin
         fault_q <= fault;
         if (write_strobe && (address == OFS_STATUS)) begin
            status <= (status & ~write_data[ST_W-1:0]) | events;
         end else begin
            status <= status | events;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge clock) begin
      if (reset) begin
         mask <= '0;
      end else if (write_strobe && (address == OFS_MASK)) begin
         mask <= write_data[ST_W-1:0];
      end
   end
   assign irq = |(status & mask);

   // Blink phase toggles each second
   always_ff @(posedge clock) begin
      if (reset) begin
         blink <= 1'b0;
      end else if (tick) begin
         blink <= !blink;
      end
   end

   // Transmit request: master each minute and on local change,
   // follower with remote only on local change
   always_ff @(posedge clock) begin
      if (reset) begin
         tx_pend     <= 1'b0;
         tx_pend_adj <= 1'b0;
      end else begin
         tx_pend     <= 1'b0;
         tx_pend_adj <= 1'b0;
         if (master && ((tick && sec_end) || wr_time || wr_date)) begin
            tx_pend <= 1'b1;
         end else if (follow && remote_adj && (wr_time || wr_date)) begin
            tx_pend     <= 1'b1;
            tx_pend_adj <= 1'b1;
         end
      end
   end

   // Broadcast carries the time as it stands after the update
   always_ff @(posedge clock) begin
      if (reset) begin
         tx_valid  <= 1'b0;
         tx_adjust <= 1'b0;
         tx_time   <= '0;
         tx_date   <= '0;
      end else begin
         tx_valid  <= tx_pend;
         tx_adjust <= tx_pend_adj;
         if (tx_pend) begin
            tx_time <= {wday, hour, min, sec};
            tx_date <= {year, mon, day};
         end
      end
   end

   // Presented hour in the chosen format
   logic [4:0] show_hour;
   logic       show_pm;
   always_comb begin
      show_pm   = fmt_12h && (hour >= 5'h0C);
      show_hour = hour;
      if (fmt_12h) begin
         if (hour == 5'h00) begin
            show_hour = 5'h0C;
         end else if (hour > 5'h0C) begin
            show_hour = hour - 5'h0C;
         end
      end
   end

   // Registered read data, valid the cycle after the strobe
   always_ff @(posedge clock) begin
      if (reset || !read_strobe) begin
         read_data <= '0;
      end else begin
         case (address)
            OFS_CTRL:    read_data <= {28'h0, remote_adj, mode, fmt_12h};
            OFS_TIME:    read_data <= {5'h0, wday, 3'h0, hour,
                                       2'h0, min, 2'h0, sec};
            OFS_DATE:    read_data <= {9'h0, year, 4'h0, mon, 3'h0, day};
            OFS_SEASON:  read_data <= {4'h0, win_mon, 3'h0, win_day,
                                       4'h0, sum_mon, 3'h0, sum_day};
            OFS_STATUS:  read_data <= {28'h0, status};
            OFS_MASK:    read_data <= {28'h0, mask};
            OFS_FAULT:   read_data <= {26'h0, sum_pend, dst_on, fault};
            // Invalid time blanks every other second
            OFS_DISPLAY: read_data <= {21'h0, !(invalid && blink),
                                       fmt_12h, show_pm,
                                       3'h0, show_hour};
            default:     read_data <= '0;
         endcase
      end
   end
endmodule
`default_nettype wire

// [ccbs_pkg.sv]
// Functional notes
// - Keep time of day, weekday and date
// - 24-hour default; 12-hour am/pm selectable
// - Seasonal shifts automatic from set dates
// - Summer: first Sunday after, 02:00 to 03:00
// - Winter: first Sunday after, 03:00 to 02:00
// - Equal start dates disable seasonal shifts
// - Standalone: no bus time sent or taken
// - Follower: bus time is the reference
// - Master: broadcast time onto the bus
// - Standalone: local setting, no bus alignment
// - Follower without remote: refuse local setting
// - Follower with remote: local change sent out
// - Master: local change updates system time
// - Several masters raise fault 5002, acknowledged
// - Follower without bus time: fault 5001
// - Time lost, not resupplied: fault 5003
// - Invalid time shown blinking
package ccbs_pkg;
   // Register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_TIME    = 8'h04;
   localparam logic [7:0] OFS_DATE    = 8'h08;
   localparam logic [7:0] OFS_SEASON  = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_MASK    = 8'h14;
   localparam logic [7:0] OFS_FAULT   = 8'h18;
   localparam logic [7:0] OFS_DISPLAY = 8'h1C;
   // Clock mode codes
   localparam logic [1:0] MODE_ALONE  = 2'h0;
   localparam logic [1:0] MODE_FOLLOW = 2'h1;
   localparam logic [1:0] MODE_MASTER = 2'h2;
   // Status and fault bit positions
   localparam int ST_SYSFAIL = 0;
   localparam int ST_MULTI   = 1;
   localparam int ST_INVALID = 2;
   localparam int ST_SHIFT   = 3;
   localparam int ST_W       = 4;
   // Reset values and the Sunday weekday code
   localparam logic [4:0] RST_SUM_DAY = 5'h19;
   localparam logic [3:0] RST_SUM_MON = 4'h3;
   localparam logic [4:0] RST_WIN_DAY = 5'h19;
   localparam logic [3:0] RST_WIN_MON = 4'hA;
   localparam logic [2:0] RST_WDAY    = 3'h5;
   localparam logic [2:0] SUNDAY      = 3'h6;
   // Timing
   localparam int CLK_HZ       = 50_000_000;
   localparam int TICK_S       = 1;
   localparam int TICK_CYCLES  = CLK_HZ * TICK_S;
   localparam int BUS_LOSS_S   = 60;
endpackage

// [ccbs_top_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module ccbs_top_sva #(
   parameter int TICK_CYCLES = ccbs_pkg::TICK_CYCLES,
   parameter int BUS_LOSS_S  = ccbs_pkg::BUS_LOSS_S
) (
   input wire logic                        clock,
   input wire logic                        reset,
   input wire logic [ccbs_pkg::ADDR_W-1:0] address,
   input wire logic [ccbs_pkg::DATA_W-1:0] write_data,
   input wire logic                        write_strobe,
   input wire logic                        read_strobe,
   input wire logic [ccbs_pkg::DATA_W-1:0] read_data,
   input wire logic                        irq,
   input wire logic                        rx_valid,
   input wire logic [19:0]                 rx_time,
   input wire logic [15:0]                 rx_date,
   input wire logic                        rx_master_seen,
   input wire logic                        tx_valid,
   input wire logic                        tx_adjust,
   input wire logic [19:0]                 tx_time,
   input wire logic [15:0]                 tx_date
);
   import ccbs_pkg::*;
   logic [1:0]      mode_q; // Mode as last written
   logic            radj_q; // Remote adjustment enable
   logic [ST_W-1:0] mask_q; // Interrupt mask copy
   logic [19:0]     wt_q;   // Last time write, link layout
   logic [19:0]     rx_q;   // Last bus time offered
   // Shadow of control and mask, so rules can key on the mode
   always_ff @(posedge clock) begin
      if (reset) begin
         mode_q <= MODE_ALONE;
         radj_q <= 1'h1;
         mask_q <= '0;
      end else if (write_strobe && address == OFS_CTRL) begin
         mode_q <= write_data[2:1];
         radj_q <= write_data[3];
      end else if (write_strobe && address == OFS_MASK) begin
         mask_q <= write_data[ST_W-1:0];
      end
   end
   // Payload copies; only looked at after a load, so no reset
   always_ff @(posedge clock) begin
      if (write_strobe && address == OFS_TIME) begin
         wt_q <= {write_data[26:24], write_data[20:16], write_data[13:8],
                  write_data[5:0]};
      end
      if (rx_valid) begin
         rx_q <= rx_time;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   read_idle_a: assert property (
      !$past(read_strobe) |-> read_data == '0) else $error("stray read data");
   unmapped_zero_a: assert property (
      read_strobe && address >= 8'h20 |=> read_data == '0)
      else $error("unmapped read not zero");
   tx_hold_a: assert property (
      !tx_valid |-> $stable(tx_time) && $stable(tx_date))
      else $error("bus time moved without valid");
   adj_with_tx_a: assert property (
      tx_adjust |-> tx_valid) else $error("adjust flag without valid");
   quiet_mode_a: assert property (
      (mode_q != MODE_MASTER && !(mode_q == MODE_FOLLOW && radj_q))[*3]
      |-> !tx_valid) else $error("time sent in a silent mode");
   master_send_a: assert property (
      write_strobe && address == OFS_TIME && mode_q == MODE_MASTER
      |-> ##2 tx_valid && !tx_adjust && tx_time == wt_q)
      else $error("master did not broadcast new time");
   remote_send_a: assert property (
      write_strobe && address == OFS_TIME && mode_q == MODE_FOLLOW && radj_q
      |-> ##2 tx_valid && tx_adjust && tx_time == wt_q)
      else $error("follower adjustment not sent");
   follow_load_a: assert property (
      mode_q == MODE_FOLLOW && rx_valid ##1 read_strobe && address == OFS_TIME
      |=> {read_data[26:24], read_data[20:16], read_data[13:8]} == rx_q[19:6])
      else $error("bus time not taken");
   mask_quiet_a: assert property (
      mask_q == '0 |-> !irq) else $error("interrupt while all masked");
endmodule
bind ccbs_top ccbs_top_sva #(
   .TICK_CYCLES(TICK_CYCLES),
   .BUS_LOSS_S(BUS_LOSS_S)
) i_sva (
   .clock(clock), .reset(reset), .address(address),
   .write_data(write_data), .write_strobe(write_strobe),
   .read_strobe(read_strobe), .read_data(read_data), .irq(irq),
   .rx_valid(rx_valid), .rx_time(rx_time), .rx_date(rx_date),
   .rx_master_seen(rx_master_seen), .tx_valid(tx_valid),
   .tx_adjust(tx_adjust), .tx_time(tx_time), .tx_date(tx_date)
);
`default_nettype wire

// [ccbs_bus_peer.sv]
`timescale 1ns/10ps
`default_nettype none
// Another controller on the building bus
module ccbs_bus_peer (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        p_send,
   input  wire logic        p_master,
   input  wire logic [19:0] p_time,
   input  wire logic [15:0] p_date,
   input  wire logic        tx_valid,
   input  wire logic        tx_adjust,
   input  wire logic [19:0] tx_time,
   output logic             rx_valid,
   output logic             rx_master_seen,
   output logic      [19:0] rx_time,
   output logic      [15:0] rx_date,
   output logic      [19:0] sys_time,
   output logic             sys_adj
);
   // Offers bus time; idle lines show the inverse of the last value
   // so a design that samples without valid picks up garbage
   always_ff @(posedge clock) begin
      if (reset) begin
         rx_valid <= 1'h0;
         rx_master_seen <= 1'h0;
         rx_time <= '0;
         rx_date <= '0;
      end else begin
         rx_valid <= p_send;
         rx_master_seen <= p_master;
         rx_time <= p_send ? p_time : ~rx_time;
         rx_date <= p_send ? p_date : ~rx_date;
      end
   end
   // System time of the bus, taken from broadcasts and adjustments
   always_ff @(posedge clock) begin
      if (reset) begin
         sys_time <= '0;
         sys_adj <= 1'h0;
      end else if (tx_valid) begin
         sys_time <= tx_time;
         sys_adj <= tx_adjust;
      end
   end
endmodule
`default_nettype wire

// [ccbs_top_test.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("mismatch %s exp %0h got %0h", n, e, g); \
   end \
end
module ccbs_top_test;
   import ccbs_pkg::*;
   localparam int TCK = 100; // Short second keeps the run brief
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   localparam logic [31:0] NOSEC = 32'hFFFF_FF00; // Seconds may tick on
   typedef struct packed {
      logic [7:0]  a; // Offset
      logic        w; // Write first
      logic [31:0] d; // Written value
      logic [31:0] e; // Expected read
   } ccbs_row_t;
   logic        clock, reset, write_strobe, read_strobe, irq, rx_valid;
   logic        rx_master_seen, tx_valid, tx_adjust, p_send, p_master, sys_adj;
   logic [7:0]  address;
   logic [31:0] write_data, read_data, v1, v2;
   logic [19:0] rx_time, tx_time, p_time, sys_time;
   logic [15:0] rx_date, tx_date, p_date;
   int          err_total, num_checks;
   ccbs_row_t   rows [7] = '{'{OFS_CTRL, 1'h0, 32'h0, 32'h8},
      '{OFS_SEASON, 1'h0, 32'h0, 32'h0A19_0319},
      '{OFS_DATE, 1'h0, 32'h0, 32'h101}, '{OFS_TIME, 1'h0, 32'h0, 32'h500_0000},
      '{OFS_FAULT, 1'h1, 32'hFF, 32'h4}, '{OFS_MASK, 1'h0, 32'h0, 32'h0},
      '{8'h20, 1'h1, ALL, 32'h0}};
   ccbs_top #(.TICK_CYCLES(TCK), .BUS_LOSS_S(3)) i_dut (
      .clock(clock), .reset(reset), .address(address),
      .write_data(write_data), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .read_data(read_data), .irq(irq),
      .rx_valid(rx_valid), .rx_time(rx_time), .rx_date(rx_date),
      .rx_master_seen(rx_master_seen), .tx_valid(tx_valid),
      .tx_adjust(tx_adjust), .tx_time(tx_time), .tx_date(tx_date));
   ccbs_bus_peer i_peer (
      .clock(clock), .reset(reset), .p_send(p_send), .p_master(p_master),
      .p_time(p_time), .p_date(p_date), .tx_valid(tx_valid),
      .tx_adjust(tx_adjust), .tx_time(tx_time), .rx_valid(rx_valid),
      .rx_master_seen(rx_master_seen), .rx_time(rx_time), .rx_date(rx_date),
      .sys_time(sys_time), .sys_adj(sys_adj));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1'h1;
      @(posedge clock);
      write_strobe <= 1'h0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'h1;
      @(posedge clock);
      read_strobe <= 1'h0;
      #1 v = read_data;
   endtask
   task automatic expect_rd(input logic [7:0] a, input logic [31:0] e,
                            input logic [31:0] m, input string n);
      logic [31:0] v;
      rd(a, v);
      `CHK(n, e, v & m)
   endtask
   // Load date and time, then poll until the next second lands
   task automatic tick_to(input logic [31:0] d, t, e);
      logic [31:0] v;
      int n;
      wr(OFS_DATE, d);
      wr(OFS_TIME, t);
      v = t;
      n = 0;
      while (v === t && n < TCK) begin
         rd(OFS_TIME, v);
         n++;
      end
      `CHK("time", e, v)
      if (v === t) give_verdict();
   endtask
   task automatic wait_fault(input int b, input logic e);
      logic [31:0] v;
      int n;
      n = 0;
      rd(OFS_FAULT, v);
      while (v[b] !== e && n < 400) begin
         rd(OFS_FAULT, v);
         n++;
      end
      `CHK("fault", e, v[b])
      if (v[b] !== e) give_verdict();
   endtask
   task automatic peer_send(input logic [19:0] t, input logic [15:0] d);
      @(posedge clock);
      p_time <= t;
      p_date <= d;
      p_send <= 1'h1;
      @(posedge clock);
      p_send <= 1'h0;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end
   // Guards against a hang anywhere in the sequence
   initial begin
      #2000000;
      err_total++;
      give_verdict();
   end
   initial begin
      {reset, write_strobe, read_strobe, p_send, p_master} = 5'h10;
      address = 8'h0;
      write_data = 32'h0;
      p_time = 20'h0;
      p_date = 16'h0;
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         expect_rd(rows[i].a, rows[i].e, ALL, "row");
      end
      rd(OFS_DISPLAY, v1);
      repeat (TCK - 2) @(posedge clock);
      rd(OFS_DISPLAY, v2);
      `CHK("blink", ~v1[10], v2[10])
      wr(OFS_TIME, 32'h020F_380A);
      wr(OFS_CTRL, 32'h9);
      expect_rd(OFS_DISPLAY, 32'h703, ALL, "disp");
      expect_rd(OFS_FAULT, 32'h0, ALL, "fault");
      wr(OFS_CTRL, 32'h8);
      tick_to(32'h0018_021C, 32'h0217_3B3B, 32'h0300_0000);
      expect_rd(OFS_DATE, 32'h0018_021D, ALL, "date");
      tick_to(32'h0018_021D, 32'h0317_3B3B, 32'h0400_0000);
      expect_rd(OFS_DATE, 32'h0018_0301, ALL, "date");
      wr(OFS_SEASON, 32'h0319_0319);
      tick_to(32'h0018_0318, 32'h0517_3B3B, 32'h0600_0000);
      tick_to(32'h0018_0401, 32'h0601_3B3B, 32'h0602_0000);
      wr(OFS_SEASON, 32'h0A19_0319);
      tick_to(32'h0018_0318, 32'h0517_3B3B, 32'h0600_0000);
      expect_rd(OFS_FAULT, 32'h20, ALL, "pend");
      tick_to(32'h0018_0401, 32'h0601_3B3B, 32'h0603_0000);
      expect_rd(OFS_FAULT, 32'h10, ALL, "dst");
      tick_to(32'h0018_0A18, 32'h0517_3B3B, 32'h0600_0000);
      tick_to(32'h0018_0A1C, 32'h0602_3B3B, 32'h0602_0000);
      expect_rd(OFS_FAULT, 32'h0, ALL, "dst");
      wr(OFS_CTRL, 32'hC);
      wr(OFS_TIME, 32'h0102_0304);
      repeat (3) @(posedge clock);
      `CHK("sys", 20'h220C4, sys_time)
      `CHK("adj", 1'h0, sys_adj)
      `CHK("txd", 16'h315C, tx_date)
      wr(OFS_CTRL, 32'hA);
      wr(OFS_TIME, 32'h0405_0607);
      repeat (3) @(posedge clock);
      `CHK("sys", 20'h85187, sys_time)
      `CHK("adj", 1'h1, sys_adj)
      expect_rd(OFS_TIME, 32'h0405_0600, NOSEC, "time");
      wr(OFS_CTRL, 32'h2);
      wr(OFS_TIME, 32'h0010_1010);
      expect_rd(OFS_TIME, 32'h0405_0600, NOSEC, "time");
      peer_send(20'h4A505, 16'h32CF);
      expect_rd(OFS_TIME, 32'h020A_1400, NOSEC, "time");
      expect_rd(OFS_DATE, 32'h0019_060F, ALL, "date");
      wait_fault(ST_SYSFAIL, 1'h1);
      wr(OFS_MASK, 32'h1);
      #1 `CHK("irq", 1'h1, irq)
      wr(OFS_STATUS, 32'h1);
      #1 `CHK("irq", 1'h0, irq)
      peer_send(20'h4A505, 16'h32CF);
      wait_fault(ST_SYSFAIL, 1'h0);
      wr(OFS_CTRL, 32'h8);
      peer_send(20'h21000, 16'h0);
      expect_rd(OFS_TIME, 32'h020A_1400, NOSEC, "time");
      wr(OFS_TIME, 32'h0111_2233);
      expect_rd(OFS_TIME, 32'h0111_2200, NOSEC, "time");
      `CHK("sys", 20'h85187, sys_time)
      wr(OFS_CTRL, 32'hC);
      p_master <= 1'h1;
      @(posedge clock);
      p_master <= 1'h0;
      wait_fault(ST_MULTI, 1'h1);
      expect_rd(OFS_STATUS, 32'h2, 32'h2, "stat");
      wr(OFS_STATUS, 32'h2);
      wait_fault(ST_MULTI, 1'h0);
      @(posedge clock) reset <= 1'h1;
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      expect_rd(OFS_TIME, 32'h0500_0000, ALL, "time");
      expect_rd(OFS_FAULT, 32'h4, ALL, "fault");
      expect_rd(OFS_STATUS, 32'h4, ALL, "stat");
      give_verdict();
   end
endmodule
`default_nettype wire
